// ### core/tmc_cfg.svh
// Notes on behaviour
// - Muting limit selectable: 20 s, 2 min, 10 min, 100 h.
// - Muting inputs: on after 60 ms, off after 300 ms.
// - Muting starts and holds only with both inputs.
// - Outputs stay on during muting despite broken beams.
// - Enable option: muting starts only while enable asserted.
// - Override only with a muting input, outputs off.
// - Override ends when no muting input remains.
// - Override switches the safety outputs on.
// - Override limits muting to 10 minutes.
// - Override: 0.2-4 s pulse, then held press.
// - Both inputs at override: enter muting directly.
// - One input: mute on release, second within 4 s.
// - No input during override: end muting at once.
// - Enable option without extension: override only while held.
// - Any error interlocks; only a valid pulse releases.
// - Valid reset pulse lasts 0.2 s to 4 s.
// - Reset from button or machine; override uses one.
// - After field violation, outputs return on valid pulse.
// - Ready lamp steady when sensor on, outputs off; flash when beam broken with a muting input.
// - Muting error flashes ready; outputs follow field state.
// - Muting lamp off, steady when muting, flashing on error.
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH
`define TMC_CLK_HZ 25000000
`define TMC_DEB_ON_MS 60
`define TMC_DEB_OFF_MS 300
`define TMC_ENA_LEAD_MS 60
`define TMC_TO_20S_S 20
`define TMC_TO_2M_MIN 2
`define TMC_TO_10M_MIN 10
`define TMC_TO_100H_H 100
`define TMC_PULSE_MIN_MS 200
`define TMC_PULSE_MAX_MS 4000
`define TMC_SECOND_WIN_MS 4000
`define TMC_FLASH_MS 250
`define TMC_CTRL_ADDR 4'h0
`define TMC_STAT_ADDR 4'h4
`define TMC_CTRL_W 5
`define TMC_CTRL_RESET 5'h00
`endif

// ### core/tmc_pkg.sv
package tmc_pkg;
  typedef enum logic [5:0] {
    ST_LOCK = 6'h01,
    ST_OFF  = 6'h02,
    ST_RUN  = 6'h04,
    ST_MUTE = 6'h08,
    ST_OVR  = 6'h10,
    ST_OVRM = 6'h20
  } tmc_state_t;

  typedef struct packed {
    logic src_machine;
    logic ext;
    logic ena_opt;
    logic [1:0] tsel;
  } tmc_ctrl_t;

  typedef struct packed {
    logic mute_err;
    logic armed;
    logic interlock;
    logic override;
    logic muting;
    logic en_ok;
    logic second_on;
    logic first_on;
    logic outputs_on;
  } tmc_stat_t;
endpackage

// ### core/tmc_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_debounce #(
  parameter int unsigned ON_CYC = 1,
  parameter int unsigned OFF_CYC = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic level_o
);
  logic [31:0] cnt;
  logic [31:0] need;

  if (ON_CYC < 1 || OFF_CYC < 1) begin : g_chk
    $error("Debounce counts must be at least one cycle.");
  end

  assign need = raw_i ? ON_CYC : OFF_CYC;

  // A glitch shorter than the filter time restarts the count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 32'h0;
      level_o <= 1'b0;
    end else if (raw_i == level_o) begin
      cnt <= 32'h0;
    end else if (cnt >= need - 32'h1) begin
      cnt <= 32'h0;
      level_o <= raw_i;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  level_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(level_o) |-> level_o == $past(raw_i))
    else $error("Filtered level moved against the input.");
endmodule
`default_nettype wire

// ### core/tmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"
module tmc_ctrl import tmc_pkg::*; #(
  parameter int unsigned HZ = `TMC_CLK_HZ,
  parameter int unsigned DEB_ON = `TMC_DEB_ON_MS * (HZ / 1000),
  parameter int unsigned DEB_OFF = `TMC_DEB_OFF_MS * (HZ / 1000),
  parameter int unsigned ENA_LEAD = `TMC_ENA_LEAD_MS * (HZ / 1000),
  parameter int unsigned P_MIN = `TMC_PULSE_MIN_MS * (HZ / 1000),
  parameter int unsigned P_MAX = `TMC_PULSE_MAX_MS * (HZ / 1000),
  parameter int unsigned WIN = `TMC_SECOND_WIN_MS * (HZ / 1000),
  parameter int unsigned FLASH = `TMC_FLASH_MS * (HZ / 1000),
  parameter longint unsigned T20S = 64'(`TMC_TO_20S_S) * HZ,
  parameter longint unsigned T2M = 64'(`TMC_TO_2M_MIN) * 60 * HZ,
  parameter longint unsigned T10M = 64'(`TMC_TO_10M_MIN) * 60 * HZ,
  parameter longint unsigned T100H = 64'(`TMC_TO_100H_H) * 3600 * HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic first_muting_input_i,
  input wire logic second_muting_input_i,
  input wire logic optical_protective_device_on_i,
  input wire logic optical_protective_device_error_i,
  input wire logic internal_error_i,
  input wire logic button_i,
  input wire logic reset_request_input_i,
  input wire logic muting_enable_i,
  output logic safety_switching_output_o,
  output logic muting_lamp_o,
  output logic awaiting_reset_indicator_o
);
  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (P_MIN < 1 || P_MAX <= P_MIN || WIN < 1 || FLASH < 1 ||
      T20S < 2 || T10M >= 64'h1000_0000_0000 ||
      T100H >= 64'h1000_0000_0000) begin : g_chk
    $error("Timing parameters cannot be served by the counters.");
  end

  // ****************************************************************
  // Input filtering
  // ****************************************************************
  logic first_mute, second_mute, en_ok, any_ms, both, field_free, fault;

  tmc_debounce #(.ON_CYC(DEB_ON), .OFF_CYC(DEB_OFF)) u_first (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(first_muting_input_i),
    .level_o(first_mute)
  );
  tmc_debounce #(.ON_CYC(DEB_ON), .OFF_CYC(DEB_OFF)) u_second (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(second_muting_input_i),
    .level_o(second_mute)
  );
  // The enable only counts once it has stood for its lead time.
  tmc_debounce #(.ON_CYC(ENA_LEAD), .OFF_CYC(1)) u_ena (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(muting_enable_i),
    .level_o(en_ok)
  );

  assign any_ms = first_mute | second_mute;
  assign both = first_mute & second_mute;
  assign field_free = optical_protective_device_on_i;
  assign fault = optical_protective_device_error_i | internal_error_i;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  tmc_ctrl_t ctrl;
  tmc_stat_t stat;
  logic wb_hit;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= tmc_ctrl_t'(`TMC_CTRL_RESET);
    end else if (wb_hit && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `TMC_CTRL_ADDR) begin
      ctrl <= tmc_ctrl_t'(wb_dat_i[`TMC_CTRL_W-1:0]);
    end
  end

  // Unmapped addresses acknowledge and read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        `TMC_CTRL_ADDR: wb_dat_o <= 32'(ctrl);
        `TMC_STAT_ADDR: wb_dat_o <= 32'(stat);
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // Reset pulse timing
  // ****************************************************************
  tmc_state_t state, next_state;
  logic armed, src, src_q, pulse_ok, press_edge, ovr_seq;
  logic [31:0] press_cnt;

  // While an override is being keyed, only the chosen source counts,
  // so a second operator cannot complete someone else's sequence.
  assign ovr_seq = armed | (state == ST_OVR);
  assign src = ovr_seq ? (ctrl.src_machine ? reset_request_input_i
                                           : button_i)
                       : (button_i | reset_request_input_i);
  assign press_edge = src & ~src_q;
  assign pulse_ok = src_q & ~src & (press_cnt >= P_MIN) &
                    (press_cnt <= P_MAX);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= 1'b0;
      press_cnt <= 32'h0;
    end else begin
      src_q <= src;
      if (!src) begin
        press_cnt <= 32'h0;
      end else if (press_cnt <= P_MAX) begin
        press_cnt <= press_cnt + 32'h1;
      end
    end
  end

  // ****************************************************************
  // Muting timers
  // ****************************************************************
  logic restricted, to_hit, win_hit, mute_allow, hold_only;
  logic [43:0] mute_cnt;
  logic [31:0] win_cnt;
  longint unsigned limit;

  function automatic longint unsigned sel_limit(input logic [1:0] s,
                                                input logic r);
    longint unsigned v;
    unique case (s)
      2'h0: v = T20S;
      2'h1: v = T2M;
      2'h2: v = T10M;
      default: v = T100H;
    endcase
    if (r && v > T10M) begin
      v = T10M;
    end
    return v;
  endfunction

  assign limit = sel_limit(ctrl.tsel, restricted);
  assign to_hit = 64'(mute_cnt) >= limit - 64'h1;
  assign win_hit = win_cnt >= WIN - 32'h1;
  assign mute_allow = ~ctrl.ena_opt | en_ok;
  assign hold_only = ctrl.ena_opt & ~ctrl.ext;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mute_cnt <= 44'h0;
    end else if (state inside {ST_MUTE, ST_OVR, ST_OVRM}) begin
      mute_cnt <= mute_cnt + 44'h1;
    end else begin
      mute_cnt <= 44'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt <= 32'h0;
    end else if (state == ST_OVRM) begin
      win_cnt <= win_cnt + 32'h1;
    end else begin
      win_cnt <= 32'h0;
    end
  end

  // Override keeps the shorter limit until muting ends.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restricted <= 1'b0;
    end else if (state == ST_OVR) begin
      restricted <= 1'b1;
    end else if (!(state inside {ST_MUTE, ST_OVRM})) begin
      restricted <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_LOCK: begin
        if (pulse_ok) begin
          next_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (pulse_ok && field_free) begin
          next_state = ST_RUN;
        end else if (armed && press_edge && any_ms) begin
          next_state = ST_OVR;
        end
      end
      ST_RUN: begin
        if (!field_free) begin
          next_state = ST_OFF;
        end else if (both && mute_allow) begin
          next_state = ST_MUTE;
        end
      end
      ST_MUTE: begin
        if (!both || to_hit) begin
          next_state = field_free ? ST_RUN : ST_OFF;
        end
      end
      ST_OVR: begin
        if (!any_ms || to_hit) begin
          next_state = ST_OFF;
        end else if (hold_only && !src) begin
          next_state = ST_OFF;
        end else if (both) begin
          next_state = ST_MUTE;
        end else if (!src) begin
          next_state = ST_OVRM;
        end
      end
      ST_OVRM: begin
        if (both) begin
          next_state = ST_MUTE;
        end else if (!any_ms || win_hit || to_hit) begin
          next_state = ST_OFF;
        end
      end
    endcase
    if (fault) begin
      next_state = ST_LOCK;
    end
  end

  // Power-up starts interlocked so a reset pulse is always needed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_LOCK;
    end else begin
      state <= next_state;
    end
  end

  // The first valid pulse with the field broken arms an override.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed <= 1'b0;
    end else if (state != ST_OFF || !any_ms) begin
      armed <= 1'b0;
    end else if (pulse_ok && !field_free) begin
      armed <= 1'b1;
    end
  end

  // ****************************************************************
  // Muting error and indicators
  // ****************************************************************
  logic mute_err, muting, on, flash, restart_wait;
  logic [31:0] flash_cnt;

  // An expiry in the same cycle as a clearing pulse still sets.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mute_err <= 1'b0;
    end else if (to_hit && muting) begin
      mute_err <= 1'b1;
    end else if (pulse_ok) begin
      mute_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end else if (flash_cnt >= FLASH - 32'h1) begin
      flash_cnt <= 32'h0;
      flash <= ~flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  assign muting = state inside {ST_MUTE, ST_OVR, ST_OVRM};
  assign on = muting | (state == ST_RUN);
  assign restart_wait = (state == ST_OFF) & ~field_free & any_ms;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      safety_switching_output_o <= 1'b0;
      muting_lamp_o <= 1'b0;
      awaiting_reset_indicator_o <= 1'b0;
    end else begin
      safety_switching_output_o <= on;
      muting_lamp_o <= mute_err ? flash : muting;
      if (mute_err || restart_wait) begin
        awaiting_reset_indicator_o <= flash;
      end else begin
        awaiting_reset_indicator_o <= field_free & ~on;
      end
    end
  end

  assign stat = '{mute_err: mute_err, armed: armed,
                  interlock: state == ST_LOCK,
                  override: state inside {ST_OVR, ST_OVRM},
                  muting: muting, en_ok: en_ok, second_on: second_mute,
                  first_on: first_mute,
                  outputs_on: safety_switching_output_o};

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  fault_locks_a: assert property (fault |=> state == ST_LOCK)
    else $error("Error did not interlock.");
  lock_release_a: assert property (
    state == ST_LOCK ##1 state == ST_OFF |-> $past(pulse_ok))
    else $error("Interlock left without a valid pulse.");
  lock_dark_a: assert property (
    state == ST_LOCK [*2] |-> !safety_switching_output_o)
    else $error("Outputs on while interlocked.");
  mute_start_a: assert property (
    state == ST_RUN ##1 state == ST_MUTE |->
    $past(both) && (!$past(ctrl.ena_opt) || $past(en_ok)))
    else $error("Muting began without both inputs or enable.");
  mute_held_a: assert property (
    state == ST_MUTE |=> safety_switching_output_o)
    else $error("Outputs dropped during muting.");
  ovr_entry_a: assert property (
    $rose(state == ST_OVR) |-> $past(any_ms) &&
    $past(state) == ST_OFF && !$past(safety_switching_output_o))
    else $error("Override entered illegally.");
  ovr_on_a: assert property (
    state == ST_OVR |=> safety_switching_output_o)
    else $error("Override did not switch outputs on.");
  ovr_end_a: assert property (
    state inside {ST_OVR, ST_OVRM} && !any_ms |=>
    state inside {ST_OFF, ST_LOCK})
    else $error("Override kept without muting input.");
  ovr_limit_a: assert property (
    state inside {ST_OVR, ST_OVRM} |=> limit <= T10M)
    else $error("Override limit above ten minutes.");
  hold_only_a: assert property (
    state == ST_OVR && hold_only && !src |=>
    state inside {ST_OFF, ST_LOCK})
    else $error("Override survived button release.");
  second_win_a: assert property (
    state == ST_OVRM && win_hit && !both |=> state != ST_OVRM)
    else $error("Second input window overran.");
  restart_pulse_a: assert property (
    state == ST_OFF ##1 state == ST_RUN |-> $past(pulse_ok))
    else $error("Restart without a valid pulse.");
  timeout_err_a: assert property (
    state == ST_MUTE && to_hit && !fault |=>
    mute_err && state == ($past(field_free) ? ST_RUN : ST_OFF))
    else $error("Muting expiry mishandled.");
  ready_lamp_a: assert property (
    field_free && !on && !mute_err && !restart_wait |=>
    awaiting_reset_indicator_o)
    else $error("Ready indicator not steady.");
  mute_lamp_a: assert property (
    muting && !mute_err |=> muting_lamp_o)
    else $error("Muting lamp dark during muting.");

  mute_seen_c: cover property (state == ST_RUN ##1 state == ST_MUTE);
  ovr_seen_c: cover property (state == ST_OFF ##1 state == ST_OVR);
  ovrm_seen_c: cover property (state == ST_OVRM ##1 state == ST_MUTE);
  err_seen_c: cover property ($rose(mute_err));
endmodule
`default_nettype wire

// ### testbench/tmc_plant.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Far side: light curtain, muting sensors and machine control.
// ********************************************************************
module tmc_plant (
  input wire logic clk_i,
  input wire logic [5:0] cmd_i,
  output logic sens_a_o,
  output logic sens_b_o,
  output logic field_free_o,
  output logic mreset_o,
  output logic ena_o,
  output logic curtain_err_o
);
  // Every switching output changes just after an edge, as a real sensor
  // output would, so the device never sees a change at its own edge.
  always_ff @(posedge clk_i) begin
    sens_a_o <= cmd_i[0];
    sens_b_o <= cmd_i[1];
    field_free_o <= cmd_i[2];
    curtain_err_o <= cmd_i[5];
  end

  // The machine line and the enable also follow the bench commands one edge later.
  always_ff @(posedge clk_i) begin
    mreset_o <= cmd_i[3];
    ena_o <= cmd_i[4];
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmc_pkg::*;
  localparam int DON = 4;
  localparam int DOFF = 8;
  localparam int WN = 10;
  localparam int LEAD = 4;
  localparam int PMIN = 5;
  localparam int PMAX = 20;
  localparam int FLC = 3;
  localparam longint unsigned L20S = 50;
  localparam longint unsigned L2M = 60;
  localparam longint unsigned L10M = 80;
  localparam longint unsigned L100H = 200;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic ack, btn = 1'b0, ierr = 1'b0, safe_out, lamp, ready;
  logic sens_a, sens_b, ffree, mres, ena, cerr;
  logic [5:0] cmd = 6'h04;
  int err_total = 0, samples_checked = 0;
  int lim[4] = '{50, 60, 80, 200};

  always #20 clk = ~clk;

  tmc_plant plant (.clk_i(clk), .cmd_i(cmd), .sens_a_o(sens_a),
    .sens_b_o(sens_b), .field_free_o(ffree), .mreset_o(mres),
    .ena_o(ena), .curtain_err_o(cerr));

  tmc_ctrl #(.DEB_ON(DON), .DEB_OFF(DOFF), .ENA_LEAD(LEAD), .P_MIN(PMIN),
    .P_MAX(PMAX), .WIN(WN), .FLASH(FLC), .T20S(L20S), .T2M(L2M),
    .T10M(L10M), .T100H(L100H)) dut (.clk_i(clk), .rst_i(rst),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .first_muting_input_i(sens_a), .second_muting_input_i(sens_b),
    .optical_protective_device_on_i(ffree),
    .optical_protective_device_error_i(cerr), .internal_error_i(ierr),
    .button_i(btn), .reset_request_input_i(mres),
    .muting_enable_i(ena), .safety_switching_output_o(safe_out),
    .muting_lamp_o(lamp), .awaiting_reset_indicator_o(ready));

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pin(input logic v, input logic e);
    chk({31'h0, v}, {31'h0, e});
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wb(input logic [3:0] a, input logic wr,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n = 0;
    @(posedge clk);
    adr <= a;
    we <= wr;
    dat <= d;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      err_total++;
      finish_test();
    end
  endtask

  task automatic sb(input int i, input logic e);
    logic [31:0] r;
    wb(4'h4, 1'b0, 32'h0, 4'hf, r);
    pin(r[i], e);
  endtask

  // A lamp that flashes is seen both lit and dark over a few periods.
  task automatic fl(input logic which);
    int ones = 0;
    repeat (12) begin
      @(posedge clk);
      if ((which ? ready : lamp) === 1'b1) ones++;
    end
    pin(ones > 0 && ones < 12, 1'b1);
  endtask

  task automatic pulse(input logic m, input int n);
    @(posedge clk);
    if (m) cmd[3] <= 1'b1;
    else btn <= 1'b1;
    w(n);
    cmd[3] <= 1'b0;
    btn <= 1'b0;
    w(5);
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    w(8);
    rst <= 1'b0;
    w(1);
    pin(safe_out, 1'b0);
    sb(6, 1'b1);
    // Unmapped writes and writes without the low byte lane are ignored.
    wb(4'h8, 1'b1, 32'hffffffff, 4'hf, q);
    wb(4'h0, 1'b1, 32'h1f, 4'he, q);
    wb(4'h8, 1'b0, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    wb(4'h0, 1'b0, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    pulse(0, 3);
    sb(6, 1'b1);
    pulse(0, 25);
    sb(6, 1'b1);
    pulse(0, 8);
    sb(6, 1'b0);
    pin(ready, 1'b1);
    pulse(0, 8);
    pin(safe_out, 1'b1);
    pin(ready, 1'b0);
    cmd[0] <= 1'b1;
    w(DON + 8);
    sb(4, 1'b0);
    cmd[1] <= 1'b1;
    sb(4, 1'b0);
    w(DON + 6);
    sb(4, 1'b1);
    pin(lamp, 1'b1);
    cmd[2] <= 1'b0;
    w(4);
    pin(safe_out, 1'b1);
    cmd[1] <= 1'b0;
    sb(4, 1'b1);
    w(DOFF + 4);
    sb(4, 1'b0);
    pin(safe_out, 1'b0);
    fl(1'b1);
    pulse(0, 8);
    sb(7, 1'b1);
    btn <= 1'b1;
    w(4);
    pin(safe_out, 1'b1);
    sb(5, 1'b1);
    btn <= 1'b0;
    w(5);
    pin(safe_out, 1'b1);
    w(WN + 4);
    pin(safe_out, 1'b0);
    pulse(0, 8);
    btn <= 1'b1;
    w(4);
    pin(safe_out, 1'b1);
    cmd[0] <= 1'b0;
    w(DOFF + 6);
    pin(safe_out, 1'b0);
    btn <= 1'b0;
    cmd[0] <= 1'b1;
    wb(4'h0, 1'b1, 32'h3, 4'hf, q);
    w(DON + 4);
    pulse(0, 8);
    btn <= 1'b1;
    w(2);
    cmd[1] <= 1'b1;
    w(DON + 6);
    sb(4, 1'b1);
    btn <= 1'b0;
    w(40);
    pin(safe_out, 1'b1);
    w(50);
    pin(safe_out, 1'b0);
    cmd <= 6'h04;
    w(DOFF + 6);
    pulse(0, 8);
    pin(safe_out, 1'b1);
    // Each limit is probed just before and well after it runs out.
    for (int i = 0; i < 4; i++) begin
      wb(4'h0, 1'b1, 32'(i), 4'hf, q);
      cmd[1:0] <= 2'h3;
      w(DON + 4);
      w(lim[i] - 12);
      sb(4, 1'b1);
      w(24);
      sb(8, 1'b1);
      pin(safe_out, 1'b1);
      fl(1'b0);
      fl(1'b1);
      cmd[1:0] <= 2'h0;
      w(DOFF + 6);
      pulse(0, 8);
      sb(8, 1'b0);
    end
    wb(4'h0, 1'b1, 32'h4, 4'hf, q);
    cmd[1:0] <= 2'h3;
    w(DON + 10);
    sb(4, 1'b0);
    cmd[1:0] <= 2'h0;
    w(DOFF + 6);
    cmd[4] <= 1'b1;
    w(8);
    cmd[1:0] <= 2'h3;
    w(DON + 6);
    sb(4, 1'b1);
    cmd <= 6'h04;
    w(DOFF + 6);
    // Enable option without extension: override lasts only while held.
    cmd[2:0] <= 3'h1;
    w(DON + 6);
    pulse(0, 8);
    btn <= 1'b1;
    w(4);
    pin(safe_out, 1'b1);
    btn <= 1'b0;
    w(4);
    pin(safe_out, 1'b0);
    // With the extension, release leads to the second-input window.
    wb(4'h0, 1'b1, 32'h0c, 4'hf, q);
    pulse(0, 8);
    btn <= 1'b1;
    w(4);
    btn <= 1'b0;
    w(5);
    pin(safe_out, 1'b1);
    w(WN + 4);
    pin(safe_out, 1'b0);
    // Machine line chosen: the local button cannot key the override.
    wb(4'h0, 1'b1, 32'h14, 4'hf, q);
    pulse(1, 8);
    btn <= 1'b1;
    w(4);
    pin(safe_out, 1'b0);
    btn <= 1'b0;
    cmd[3] <= 1'b1;
    w(5);
    pin(safe_out, 1'b1);
    cmd[3] <= 1'b0;
    w(6);
    pin(safe_out, 1'b0);
    cmd <= 6'h04;
    wb(4'h0, 1'b1, 32'h0, 4'hf, q);
    w(DOFF + 6);
    pulse(0, 8);
    pin(safe_out, 1'b1);
    // Both error sources; recovery uses both reset sources.
    for (int i = 0; i < 2; i++) begin
      if (i == 0) ierr <= 1'b1;
      else cmd[5] <= 1'b1;
      w(4);
      pin(safe_out, 1'b0);
      ierr <= 1'b0;
      cmd[5] <= 1'b0;
      sb(6, 1'b1);
      pulse(i[0], 8);
      sb(6, 1'b0);
      pulse(i[0], 8);
      pin(safe_out, 1'b1);
    end
    finish_test();
  end
endmodule
`default_nettype wire
